// >>> ucrd_pkg.sv
`default_nettype none
package ucrd_pkg;
  // Widths of the word bus and the select address
  localparam int WORD_W = 16;
  localparam int ADDR_W = 5;
  // Words in one cell on the 16-bit bus
  localparam int CELL_WORDS = 27;
  // Parity sense: 0 even, 1 odd; reset value is even
  localparam logic PAR_EVEN = 1'h0;
  localparam logic PAR_ODD = 1'h1;
  localparam logic PAR_RESET = PAR_EVEN;
  // Word counter width and constants; cells of up to 32 words fit
  localparam int WCNT_W = 5;
  localparam logic [WCNT_W-1:0] WCNT_ZERO = 5'h00;
  localparam logic [WCNT_W-1:0] WCNT_ONE = 5'h01;
endpackage
`default_nettype wire

// >>> ucrd_port.sv
`timescale 1ns/1ps
`default_nettype none
module ucrd_port #(
  parameter int CELL_WORDS = ucrd_pkg::CELL_WORDS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Master side
  input wire logic rx_read_enable_n_i,
  input wire logic [ucrd_pkg::ADDR_W-1:0] rx_select_address_i,
  input wire logic [ucrd_pkg::ADDR_W-1:0] device_poll_address_i,
  input wire logic any_phy_mode_select_i,
  // Configuration
  input wire logic parity_odd_i,
  input wire logic parity_load_i,
  // Cell buffer side
  input wire logic [ucrd_pkg::WORD_W-1:0] buf_word_i,
  output logic buf_pop_o,
  // Word bus pins
  output logic [ucrd_pkg::WORD_W-1:0] rx_cell_word_bus_o,
  output logic rx_cell_word_bus_oe_o,
  output logic rx_word_parity_o,
  output logic rx_word_parity_oe_o
);
  // Counter width; cells longer than the counter can hold are not
  // supported, so keep CELL_WORDS within its range
  localparam int CNT_W = ucrd_pkg::WCNT_W;
  // Index of the closing word of a cell, cut to the counter width
  localparam int LAST_INT = CELL_WORDS - 1;
  localparam logic [CNT_W-1:0] LAST_IDX = LAST_INT[CNT_W-1:0];

  // All state of the port, one packed record
  typedef struct packed {
    logic sel; // Selected for transfer
    logic enb_prev_hi; // Enable was high at the previous edge
    logic [CNT_W-1:0] wcnt; // Words sent in current cell
    logic par_odd; // Parity sense
    logic [ucrd_pkg::WORD_W-1:0] dat; // Word shown on the bus
    logic par; // Parity shown with that word
    logic oe; // Bus and parity are driven
    logic pend; // Any-phy: a word was taken, drive next cycle
    logic [ucrd_pkg::WORD_W-1:0] pdat; // Any-phy: word held one cycle
  } ucrd_state_t;

  // Registered state and its next value
  ucrd_state_t st_reg;
  ucrd_state_t st_next;
  // Decoded strobes, all combinational
  logic take; // A word leaves this cycle
  logic match; // Master addresses this device
  logic last; // Current word closes the cell

  // The master names this device by matching the static address
  assign match = (rx_select_address_i == device_poll_address_i);
  // A word leaves when selected and the enable is sampled low
  assign take = st_reg.sel && !rx_read_enable_n_i;
  // Counter at the closing index means this word ends the cell
  assign last = (st_reg.wcnt == LAST_IDX);
  // The buffer advances exactly once per word taken
  assign buf_pop_o = take;

  // Next-state logic: selection, counting, capture and drive
  always_comb begin
    // Default: hold everything
    st_next = st_reg;
    // Track the enable so a fresh selection can be told apart
    st_next.enb_prev_hi = rx_read_enable_n_i;
    // Sense may be loaded at any time; a load while a word stands
    // only affects the next word captured
    if (parity_load_i) begin
      st_next.par_odd = parity_odd_i;
    end
    // Selection follows the address only while the enable is high, so the address
    // seen at the last high sample decides the transfer
    if (rx_read_enable_n_i) begin
      st_next.sel = match;
    end
    // Word counting and end-of-cell handling
    if (take) begin
      if (last) begin
        // Wrap for the next cell
        st_next.wcnt = ucrd_pkg::WCNT_ZERO;
      end else begin
        // Step to the next word of the cell
        st_next.wcnt = st_reg.wcnt + ucrd_pkg::WCNT_ONE;
      end
      // Any-phy drops the selection after the closing word
      if (last && any_phy_mode_select_i) begin
        st_next.sel = 1'h0;
      end
    end
    if (any_phy_mode_select_i) begin
      // Word captured now, shown one cycle later; the extra stage
      // costs a register but keeps the pins straight off flops
      st_next.pend = take;
      st_next.pdat = buf_word_i;
      st_next.oe = st_reg.pend;
      if (st_reg.pend) begin
        // Parity bit makes the total over word and bit equal the sense
        st_next.dat = st_reg.pdat;
        st_next.par = ^st_reg.pdat ^ st_reg.par_odd;
      end
    end else begin
      // No extra stage: nothing is pending
      st_next.pend = 1'h0;
      st_next.oe = take;
      if (take) begin
        // Show the word right after the edge that took it
        st_next.dat = buf_word_i;
        st_next.par = ^buf_word_i ^ st_reg.par_odd;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      // Quiet bus, no selection, even parity
      st_reg <= '0;
      st_reg.enb_prev_hi <= 1'h1;
      st_reg.par_odd <= ucrd_pkg::PAR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pins come straight from flip-flops; the enables tell the pads
  // when to let the shared bus float
  assign rx_cell_word_bus_o = st_reg.dat;
  assign rx_cell_word_bus_oe_o = st_reg.oe;
  assign rx_word_parity_o = st_reg.par;
  assign rx_word_parity_oe_o = st_reg.oe;

  // Mode low: a taken word is driven right after the edge
  chk_oe_follows_take: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !any_phy_mode_select_i && take |=> rx_cell_word_bus_oe_o)
    else $error("bus not driven after take");

  // Any-phy: a taken word is driven two edges later
  chk_anyphy_delay: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && take |-> ##2 rx_cell_word_bus_oe_o)
    else $error("any-phy latency wrong");

  // Any-phy: a fresh take is not driven after only one edge
  chk_anyphy_no_early: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && take && !st_reg.pend
    |=> !rx_cell_word_bus_oe_o)
    else $error("any-phy word driven too early");

  // Mode low: enable sampled high floats the bus at once
  chk_release_hi: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !any_phy_mode_select_i && rx_read_enable_n_i
    |=> !rx_cell_word_bus_oe_o)
    else $error("bus not released");

  // Any-phy: release follows the enable one cycle later
  chk_anyphy_release: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && rx_read_enable_n_i
    |=> ##1 !rx_cell_word_bus_oe_o)
    else $error("any-phy bus not released");

  // Reset leaves the bus undriven and the port deselected
  chk_reset_quiet: assert property (
    @(posedge mclk_i)
    rst_i |=> !rx_cell_word_bus_oe_o && !st_reg.sel)
    else $error("bus active after reset");

  // Word plus parity bit carries the sense in force the cycle before it is driven
  chk_par_value: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rx_word_parity_oe_o |-> ((^rx_cell_word_bus_o ^ rx_word_parity_o)
    == $past(st_reg.par_odd)))
    else $error("parity wrong");

  // Mode low: parity is driven with the word
  chk_par_oe: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !any_phy_mode_select_i && take |=> rx_word_parity_oe_o)
    else $error("parity not driven after take");

  // Any-phy: parity takes the same extra cycle as the word
  chk_par_anyphy: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && take |-> ##2 rx_word_parity_oe_o)
    else $error("any-phy parity latency wrong");

  // Any-phy: the closing word drops the selection
  chk_auto_desel: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && take && last && !rx_read_enable_n_i
    |=> !st_reg.sel)
    else $error("no deselect after cell");

  // Any-phy: after the closing word no further word is taken
  chk_desel_quiet: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && take && last |=> !buf_pop_o)
    else $error("word taken after cell end");

  // Matching address while the enable is high selects the port
  chk_select_match: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rx_read_enable_n_i && match |=> st_reg.sel)
    else $error("match did not select");

  // Another address while the enable is high deselects the port
  chk_deselect_miss: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rx_read_enable_n_i && !match |=> !st_reg.sel)
    else $error("mismatch did not deselect");

  // Selection only ever starts from a high enable sample
  chk_sel_at_high: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $rose(st_reg.sel) |-> st_reg.enb_prev_hi)
    else $error("selected while enable low");

  // Mode low: the bus shows the word taken at the previous edge
  chk_word_data: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !any_phy_mode_select_i && take
    |=> rx_cell_word_bus_o == $past(buf_word_i))
    else $error("word not presented");

  // Any-phy: the bus shows the word taken two edges before
  chk_anyphy_word: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    any_phy_mode_select_i && take
    |-> ##2 rx_cell_word_bus_o == $past(buf_word_i, 2))
    else $error("any-phy word not presented");

  // The closing word wraps the counter for the next cell
  chk_count_wrap: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    take && last |=> st_reg.wcnt == ucrd_pkg::WCNT_ZERO)
    else $error("word counter did not wrap");

  // Reset leaves even parity selected
  chk_par_reset: assert property (
    @(posedge mclk_i)
    $past(rst_i) |-> st_reg.par_odd == ucrd_pkg::PAR_EVEN)
    else $error("parity sense reset wrong");
endmodule
`default_nettype wire

// >>> ucrd_master.sv
`timescale 1ns/1ps
`default_nettype none
// Master model: polls an address, then pulls words
module ucrd_master (
  // Clock
  input wire logic mclk_i,
  // Toward the port
  output logic en_n_o,
  output logic [ucrd_pkg::ADDR_W-1:0] addr_o
);
  initial begin
    en_n_o = 1'h1;
    addr_o = '0;
  end
  // Select with enable high, then hold enable low for n cycles
  task automatic pull(input logic [4:0] a, input int n);
    @(negedge mclk_i);
    en_n_o = 1'h1;
    addr_o = a;
    @(negedge mclk_i);
    en_n_o = 1'h0;
    repeat (n) @(negedge mclk_i);
    en_n_o = 1'h1;
  endtask
endmodule
`default_nettype wire

// >>> test_upstream_cell_read_data_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_upstream_cell_read_data_port;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic mode = 1'h0;
  logic odd = 1'h0;
  logic ld = 1'h0;
  // Buffer words are a running count over a base
  logic [15:0] cnt = 16'h0000;
  logic [15:0] exp = 16'h0000;
  wire logic en_n, pop, doe, par, poe;
  wire logic [4:0] addr;
  wire logic [15:0] data;
  int error_cnt = 0;
  int tests_run = 0;
  localparam logic [4:0] DEV = 5'h13;
  always #12.5 mclk_i = ~mclk_i;
  // Buffer model advances on every pop
  always @(posedge mclk_i) if (pop) cnt <= cnt + 16'h0001;
  ucrd_master i_ucrd_master (.mclk_i(mclk_i), .en_n_o(en_n), .addr_o(addr));
  // Short cell keeps the auto-deselect case quick
  ucrd_port #(.CELL_WORDS(4)) i_ucrd_port (.mclk_i(mclk_i), .rst_i(rst_i),
    .rx_read_enable_n_i(en_n), .rx_select_address_i(addr),
    .device_poll_address_i(DEV), .any_phy_mode_select_i(mode),
    .parity_odd_i(odd), .parity_load_i(ld), .buf_word_i(16'hA500 + cnt),
    .buf_pop_o(pop), .rx_cell_word_bus_o(data),
    .rx_cell_word_bus_oe_o(doe), .rx_word_parity_o(par),
    .rx_word_parity_oe_o(poe));
  task chk(input string nm, input logic [15:0] got, input logic [15:0] w);
    tests_run++;
    if (got !== w) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, w, got);
    end
  endtask
  task close_out;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read n words with latency lat; x extra enable-low cycles follow.
  // Select falls, enable drops a fall later, the first word is taken
  // at the next rise and seen a fall after that (plus lat)
  task automatic read(logic [4:0] a, int n, int x, int lat);
    fork
      i_ucrd_master.pull(a, n + x);
      begin
        repeat (lat + 2) @(negedge mclk_i);
        chk("early", {15'h0, doe | poe}, 16'h0000);
        for (int i = 0; i < n; i++) begin
          @(negedge mclk_i);
          chk("word", data, 16'hA500 + exp);
          chk("oe", {15'h0, doe & poe}, 16'h0001);
          chk("par", {15'h0, ^data ^ par}, {15'h0, odd});
          exp++;
        end
        @(negedge mclk_i);
        chk("idle", {15'h0, doe | poe}, 16'h0000);
      end
    join
  endtask
  // Watchdog: the scenarios need just over a microsecond
  initial begin
    #20000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_i = 1'h0;
    chk("rst", {15'h0, doe}, 16'h0000);
    read(DEV, 3, 0, 0);
    read(~DEV, 0, 2, 0);
    chk("pop", cnt, exp);
    odd = 1'h1;
    ld = 1'h1;
    @(negedge mclk_i);
    ld = 1'h0;
    read(DEV, 1, 0, 0);
    mode = 1'h1;
    read(DEV, 4, 2, 1);
    read(DEV, 2, 0, 1);
    close_out;
  end
endmodule
`default_nettype wire
